// ==== design/lamp_serial.sv ====
// serial shifter that drives the three status lamps
`timescale 1ns/1ps
`default_nettype none
`include "ring_adapter_defs.svh"
module lamp_serial (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic [2:0] lamps,
  output logic            lamp_sclk,
  output logic            lamp_sdata,
  output logic            lamp_latch
);
  logic [7:0] div_r;
  logic [1:0] bit_r;
  logic [2:0] shadow_r;

  // a full frame is resent continuously so a lost latch heals itself
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div_r      <= '0;
      bit_r      <= '0;
      shadow_r   <= '0;
      lamp_sclk  <= 1'b0;
      lamp_sdata <= 1'b0;
      lamp_latch <= 1'b0;
    end else begin
      div_r <= div_r + 8'h01;
      if (div_r == 8'h7f) begin
        lamp_sclk <= 1'b1;
      end else if (div_r == 8'hff) begin
        lamp_sclk  <= 1'b0;
        lamp_latch <= (bit_r == 2'h2);
        bit_r      <= (bit_r == 2'h2) ? 2'h0 : bit_r + 2'h1;
        if (bit_r == 2'h2) begin
          shadow_r <= lamps;
        end
        lamp_sdata <= shadow_r[bit_r];
      end
    end
  end
endmodule
`default_nettype wire

// ==== design/ring_adapter_defs.svh ====
// constants for the ring fieldbus i/o adapter
`ifndef RING_ADAPTER_DEFS_SVH
`define RING_ADAPTER_DEFS_SVH
`define CLK_MHZ          125
`define BAUD_KHZ         500
`define BIT_CYCLES       ((`CLK_MHZ * 1000) / `BAUD_KHZ)
`define HALF_BIT_CYCLES  (`BIT_CYCLES / 2)
`define WDOG_MS          640
`define WDOG_CYCLES      (`WDOG_MS * `CLK_MHZ * 1000)
`define WORD_W           16
`define FIFO_DEPTH       16
`define MAX_WORDS        32
`define ID_LEN_LSB       8
`define TYPE_IN          8'h02
`define TYPE_OUT         8'h01
`define TYPE_BOTH        8'h03
`define ERR_BIT          15
`endif

// ==== design/ring_adapter_pkg.sv ====
// types shared by the ring fieldbus i/o adapter
package ring_adapter_pkg;
  typedef enum logic [3:0] {
    ST_IDREAD = 4'h1,
    ST_IDLE   = 4'h2,
    ST_SHIFT  = 4'h4,
    ST_LATCH  = 4'h8
  } adapter_state_t;
  typedef logic [15:0] word_t;
endpackage

// ==== design/ring_io_adapter.sv ====
// ring fieldbus slave adapter between the ring ports and an i/o base
`timescale 1ns/1ps
`default_nettype none
`include "ring_adapter_defs.svh"
module ring_io_adapter
  import ring_adapter_pkg::*;
#(
  parameter int WDOG_LIMIT = `WDOG_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        supply_ok,
  input  wire logic        ring_in_data,
  input  wire logic        ring_in_frame,
  input  wire logic        ring_in_link,
  input  wire logic        master_reset,
  output logic             ring_out_data,
  output logic             ring_out_frame,
  input  wire logic        out_link_off,
  input  wire logic [15:0] base_id,
  input  wire logic        base_id_valid,
  input  wire logic [5:0]  base_in_words,
  input  wire logic [5:0]  base_out_words,
  input  wire logic [15:0] base_in_data,
  input  wire logic        base_io_error,
  output logic [15:0]      base_out_data,
  output logic             base_out_valid,
  input  wire logic        base_out_ready,
  output logic [15:0]      id_code,
  output logic             id_done,
  output logic             lamp_sclk,
  output logic             lamp_sdata,
  output logic             lamp_latch
);
  // ------------------------------------------------------------
  // input synchronisers and supply reset
  // ------------------------------------------------------------
  logic [7:0] s1_r;
  logic [7:0] s2_r;
  logic       srst_n_r;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= {base_id_valid, base_io_error, out_link_off, master_reset,
               ring_in_link, ring_in_frame, ring_in_data, supply_ok};
      s2_r <= s1_r;
    end
  end
  wire sup_ok = s2_r[0];
  wire rx_d   = s2_r[1];
  wire rx_f   = s2_r[2];
  wire lnk    = s2_r[3];
  wire mrst   = s2_r[4];
  wire ldis   = s2_r[5];
  wire ioerr  = s2_r[6];
  wire idv    = s2_r[7];

  // reset held as long as supply is out of band
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      srst_n_r <= 1'b0;
    end else begin
      srst_n_r <= sup_ok;
    end
  end

  // ------------------------------------------------------------
  // identification code
  // ------------------------------------------------------------
  function automatic logic [7:0] legal_len(input logic [5:0] n);
    if (n <= 6'd10) begin
      legal_len = (n == 6'd0) ? 8'h01 : {2'b00, n};
    end else if (n <= 6'd12) begin
      legal_len = 8'h0c;
    end else if (n <= 6'd14) begin
      legal_len = 8'h0e;
    end else if (n <= 6'd16) begin
      legal_len = 8'h10;
    end else if (n <= 6'd24) begin
      legal_len = 8'h18;
    end else begin
      legal_len = 8'h20;
    end
  endfunction

  adapter_state_t st_r;
  logic [5:0]     len_r;
  logic [15:0]    id_nxt;
  always_comb begin
    id_nxt = '0;
    id_nxt[15:`ID_LEN_LSB] = legal_len((base_in_words > base_out_words) ? base_in_words
                                                                        : base_out_words);
    id_nxt[`ID_LEN_LSB-1:0] = (base_in_words != 6'd0 && base_out_words != 6'd0) ? `TYPE_BOTH :
                              (base_in_words != 6'd0) ? `TYPE_IN : `TYPE_OUT;
  end

  // ------------------------------------------------------------
  // ring shift path: regenerate and swap own slice
  // ------------------------------------------------------------
  logic [8:0]  baud_r;
  logic [3:0]  bitc_r;
  logic [5:0]  wrd_r;
  logic [15:0] sh_r;
  logic [15:0] ins_r;
  logic [15:0] cap_r;
  logic        cap_v_r;
  logic        last_f_r;
  wire         tick = (baud_r == 9'(`BIT_CYCLES - 1));
  wire         fifo_in_ready;

  // protocol parameter channel is not decoded; only cyclic data words
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r           <= ST_IDREAD;
      id_code        <= '0;
      id_done        <= 1'b0;
      len_r          <= '0;
      baud_r         <= '0;
      bitc_r         <= '0;
      wrd_r          <= '0;
      sh_r           <= '0;
      ins_r          <= '0;
      cap_r          <= '0;
      cap_v_r        <= 1'b0;
      last_f_r       <= 1'b0;
      ring_out_data  <= 1'b1;
      ring_out_frame <= 1'b0;
    end else if (!srst_n_r) begin
      st_r           <= ST_IDREAD;
      id_done        <= 1'b0;
      cap_v_r        <= 1'b0;
      ring_out_frame <= 1'b0;
      ring_out_data  <= 1'b1;
    end else begin
      // full duplex: output follows input bit-for-bit each baud tick, except in the own slice
      baud_r   <= tick ? '0 : baud_r + 9'h001;
      cap_v_r  <= cap_v_r & ~fifo_in_ready;
      last_f_r <= rx_f;
      case (st_r)
        ST_IDREAD: begin
          if (idv) begin
            id_code <= id_nxt;
            id_done <= 1'b1;
            len_r   <= 6'(legal_len((base_in_words > base_out_words) ? base_in_words
                                                                     : base_out_words));
            st_r    <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (rx_f && !last_f_r) begin
            // restart the baud phase so every bit is taken mid-cell, not on its edge
            baud_r <= 9'(`HALF_BIT_CYCLES);
            bitc_r <= '0;
            wrd_r  <= '0;
            ins_r  <= base_in_data;
            if (ioerr) begin
              ins_r[`ERR_BIT] <= 1'b1;
            end
            st_r   <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (!rx_f) begin
            st_r <= ST_IDLE;
          end else if (tick) begin
            sh_r          <= {sh_r[14:0], rx_d};
            ring_out_frame <= 1'b1;
            // own slice: pass our word in place of the received one
            ring_out_data <= (wrd_r < len_r) ? ins_r[4'hf - bitc_r] : rx_d;
            bitc_r        <= bitc_r + 4'h1;
            if (bitc_r == 4'hf) begin
              st_r <= ST_LATCH;
            end
          end
        end
        ST_LATCH: begin
          if (wrd_r < len_r && !cap_v_r) begin
            cap_r   <= sh_r;
            cap_v_r <= 1'b1;
          end
          wrd_r <= wrd_r + 6'h01;
          ins_r <= base_in_data;
          if (ioerr) begin
            ins_r[`ERR_BIT] <= 1'b1;
          end
          st_r  <= ST_SHIFT;
        end
        default: st_r <= ST_IDREAD;
      endcase
      if (!rx_f) begin
        ring_out_frame <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // output word buffer toward the base
  // ------------------------------------------------------------
  logic [15:0] fo_data;
  logic        fo_valid;
  word_fifo #(.WIDTH(`WORD_W), .DEPTH(`FIFO_DEPTH)) u_fifo (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .in_data   (cap_r),
    .in_valid  (cap_v_r),
    .in_ready  (fifo_in_ready),
    .out_data  (fo_data),
    .out_valid (fo_valid),
    .out_ready (~base_out_valid | base_out_ready)
  );
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      base_out_data  <= '0;
      base_out_valid <= 1'b0;
    end else if (!base_out_valid || base_out_ready) begin
      base_out_valid <= fo_valid;
      base_out_data  <= fo_data;
    end
  end

  // ------------------------------------------------------------
  // watchdog and lamps
  // ------------------------------------------------------------
  logic [31:0] wd_r;
  logic        wd_exp_r;
  logic [2:0]  lamp_r;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wd_r     <= '0;
      wd_exp_r <= 1'b0;
    end else if (rx_f) begin
      wd_r     <= '0;
      wd_exp_r <= 1'b0;
    end else if (wd_r == 32'(WDOG_LIMIT - 1)) begin
      wd_exp_r <= 1'b1;
    end else begin
      wd_r <= wd_r + 32'h1;
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lamp_r <= '0;
    end else begin
      // expiry lights bus-active, kept as documented
      lamp_r[0] <= rx_f | wd_exp_r;
      lamp_r[1] <= lnk & ~mrst;
      lamp_r[2] <= ldis;
    end
  end
  lamp_serial u_lamps (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .lamps      (lamp_r),
    .lamp_sclk  (lamp_sclk),
    .lamp_sdata (lamp_sdata),
    .lamp_latch (lamp_latch)
  );

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence frame_rise_s;
    rx_f && !last_f_r;
  endsequence
  link_lamp_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ##1 (lamp_r[1] == $past(lnk & ~mrst))) else $error("link lamp wrong");
  busact_lamp_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(rx_f) |=> lamp_r[0]) else $error("bus lamp dark in frame");
  supply_rst_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !sup_ok |=> ##1 !id_done) else $error("supply reset ignored");
  wdog_lamp_a: assert property (@(posedge mclk) disable iff (!rst_n)
    wd_exp_r |=> lamp_r[0]) else $error("watchdog lamp dark");
  id_form_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(id_done) |-> id_code[15:8] != 8'h00 && id_code[7:0] inside {8'h01, 8'h02, 8'h03})
    else $error("bad id code");
  frame_start_a: assert property (@(posedge mclk) disable iff (!rst_n || !srst_n_r)
    (st_r == ST_IDLE) ##0 frame_rise_s |=> st_r == ST_SHIFT) else $error("frame missed");
  out_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    base_out_valid && !base_out_ready |=> base_out_valid && $stable(base_out_data))
    else $error("output word dropped");
  idle_frame_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !rx_f |=> !ring_out_frame) else $error("frame out without in");
endmodule
`default_nettype wire

// ==== design/word_fifo.sv ====
// parameterised valid/ready word fifo with flip-flop storage
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rp_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge mclk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// ==== test/ring_io_adapter_tb.sv ====
// self-checking bench for the ring i/o adapter and its word fifo
`timescale 1ns/1ps
`default_nettype none
module ring_io_adapter_tb;
  import ring_adapter_pkg::*;
  logic mclk, rst_n, supply_ok, rin_d, rin_f, rout_d, rout_f, rstb, id_done;
  logic base_id_valid, base_io_error, bo_valid, bo_ready;
  logic link_in, mrst_in, ldis_in, lamp_sclk, lamp_sdata, lamp_latch;
  logic [2:0] lamp_sh = '0;
  logic [5:0] n_in, n_out;
  word_t base_in_data, bo_data, id_code, rword, bi;
  word_t exp_q[$], rexp_q[$], w[$];
  int n_errors = 0;
  int checks = 0;
  int seed = 32'ha6ef0aee;
  int cyc = 0;
  int lamp_cyc = 0;
  localparam logic [5:0] TIN[6] = '{6'h03, 6'h00, 6'h18, 6'h0a, 6'h0d, 6'h02};
  localparam logic [5:0] TOUT[6] = '{6'h00, 6'h07, 6'h05, 6'h20, 6'h01, 6'h02};
  // legal reported lengths; an empty base still reports one word
  function automatic logic [7:0] rule_len(input logic [5:0] c);
    rule_len = (c == 0) ? 8'h01 : (c <= 10) ? 8'(c) : (c <= 12) ? 8'h0c : (c <= 14) ? 8'h0e :
               (c <= 16) ? 8'h10 : (c <= 24) ? 8'h18 : 8'h20;
  endfunction
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  ring_io_adapter #(.WDOG_LIMIT(1000)) ring_io_adapter_i (
    .mclk(mclk), .rst_n(rst_n), .supply_ok(supply_ok), .ring_in_data(rin_d), .ring_in_frame(rin_f),
    .ring_in_link(link_in), .master_reset(mrst_in), .ring_out_data(rout_d), .ring_out_frame(rout_f),
    .out_link_off(ldis_in), .base_id(16'h0000), .base_id_valid(base_id_valid), .base_in_words(n_in),
    .base_out_words(n_out), .base_in_data(base_in_data), .base_io_error(base_io_error),
    .base_out_data(bo_data), .base_out_valid(bo_valid), .base_out_ready(bo_ready), .id_code(id_code),
    .id_done(id_done), .lamp_sclk(lamp_sclk), .lamp_sdata(lamp_sdata), .lamp_latch(lamp_latch));
  ring_master_model ring_master_model_i (
    .mclk(mclk), .tx_data(rin_d), .tx_frame(rin_f), .rx_data(rout_d), .rx_frame(rout_f),
    .rx_word(rword), .rx_stb(rstb));
  task automatic cmp(input word_t got, input word_t exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (n_errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wait_id(input logic lvl);
    int k;
    for (k = 0; k < 3000 && id_done !== lvl; k++) @(posedge mclk);
    if (k == 3000) begin
      n_errors++;
      tally_and_finish();
    end
  endtask
  // ---------------------------------------------------------------
  // result watchers: oldest note is taken whenever a result shows
  // ---------------------------------------------------------------
  always @(posedge mclk) begin
    if (bo_valid === 1'b1 && bo_ready === 1'b1 && exp_q.size() > 0) cmp(bo_data, exp_q.pop_front());
    if (rstb === 1'b1 && rexp_q.size() > 0) cmp(rword, rexp_q.pop_front());
  end
  // lamp frame: bits arrive 0 first; judged when the latch frame is clocked,
  // only once a lamp input change has had time to travel through
  always @(posedge lamp_sclk) begin
    lamp_sh = {lamp_sdata, lamp_sh[2:1]};
    if (lamp_latch === 1'b1 && cyc - lamp_cyc > 2000)
      cmp(16'(lamp_sh[2:1]), 16'({ldis_in, link_in & ~mrst_in}));
  end
  // random stall on the base side; cycle count for lamp latency
  always @(posedge mclk) begin
    bo_ready <= 1'($random(seed));
    cyc <= cyc + 1;
  end
  initial begin
    rst_n = 1'b0;
    supply_ok = 1'b1;
    base_id_valid = 1'b1;
    base_io_error = 1'b0;
    base_in_data = '0;
    n_in = 6'h01;
    n_out = 6'h01;
    link_in = 1'b1;
    mrst_in = 1'b0;
    ldis_in = 1'b0;
    repeat (6) @(posedge mclk);
    cmp(16'(rout_d), 16'h0001);
    rst_n <= 1'b1;
    wait_id(1'b1);
    foreach (TIN[i]) begin
      @(posedge mclk);
      n_in <= TIN[i];
      n_out <= TOUT[i];
      supply_ok <= 1'b0;
      wait_id(1'b0);
      supply_ok <= 1'b1;
      wait_id(1'b1);
      cmp(id_code, {rule_len((TIN[i] > TOUT[i]) ? TIN[i] : TOUT[i]), 6'h0, TIN[i] != 0, TOUT[i] != 0});
    end
    // two frames of three words: two own, one passing through
    for (int f = 0; f < 2; f++) begin
      @(posedge mclk);
      bi = 16'($random(seed)) & 16'h7fff;
      base_in_data <= bi;
      base_io_error <= f[0];
      {link_in, mrst_in, ldis_in} <= 3'($random(seed));
      lamp_cyc = cyc;
      w.delete();
      for (int k = 0; k < 3; k++) w.push_back(16'($random(seed)));
      exp_q.push_back(w[0]);
      exp_q.push_back(w[1]);
      repeat (2) rexp_q.push_back(bi | {f[0], 15'h0});
      rexp_q.push_back(w[2]);
      ring_master_model_i.send_frame(w);
      repeat (1000) @(posedge mclk);
      cmp(16'(rout_f), 16'h0000);
    end
    for (int k = 0; k < 20000 && (exp_q.size() + rexp_q.size()) > 0; k++) @(posedge mclk);
    if (exp_q.size() + rexp_q.size() > 0) n_errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ==== test/ring_master_model.sv ====
// behavioural bus master and upstream/downstream ring neighbour
`timescale 1ns/1ps
`default_nettype none
module ring_master_model
  import ring_adapter_pkg::*;
#(
  parameter int BIT_T = 250
) (
  input  wire logic mclk,
  output logic      tx_data,
  output logic      tx_frame,
  input  wire logic rx_data,
  input  wire logic rx_frame,
  output word_t     rx_word,
  output logic      rx_stb
);
  word_t acc;
  initial begin
    tx_data = 1'b1;
    tx_frame = 1'b0;
    rx_word = '0;
    rx_stb = 1'b0;
  end
  // ---------------------------------------------------------------
  // sender: msb first, each bit held one full bit time
  // ---------------------------------------------------------------
  task automatic send_frame(input word_t w[$]);
    foreach (w[i]) begin
      for (int b = 15; b >= 0; b--) begin
        @(posedge mclk);
        tx_data <= w[i][b];
        tx_frame <= 1'b1;
        repeat (BIT_T-1) @(posedge mclk);
      end
    end
    @(posedge mclk);
    tx_data <= 1'b1;
    tx_frame <= 1'b0;
  endtask
  // ---------------------------------------------------------------
  // receiver: sample mid-bit so sync latency does not matter
  // ---------------------------------------------------------------
  always begin
    @(posedge rx_frame);
    repeat (BIT_T/2) @(posedge mclk);
    while (rx_frame === 1'b1) begin
      for (int b = 15; b >= 0; b--) begin
        acc[b] = rx_data;
        if (b > 0) repeat (BIT_T) @(posedge mclk);
      end
      rx_word <= acc;
      rx_stb <= 1'b1;
      @(posedge mclk);
      rx_stb <= 1'b0;
      repeat (BIT_T-1) @(posedge mclk);
    end
  end
endmodule
`default_nettype wire
